// File: smd_decoder.sv
// top of the smm and graphics window address decoder
`timescale 1ns/1ps
// What this block does
// - smm high region accesses remap to legacy
// - non-smm high region access aborts on bus
// - non-smm writebacks into high region still remap
// - graphics and hub cycles never reach smm
// - dram under high region stays unreachable
// - top region max 1 MB above usable
// - smm top region access hits same address
// - non-smm top region access aborts on bus
// - non-smm writebacks into top region reach dram
// - top region size from upper smm field
// - extended smm others go to hub
// - reported memory equals dram minus top region
// - top of memory to 4 GB goes hub, except window hits, which go graphics, and the drive compensation block, which goes cfg
// - io interrupt controller space goes to hub
// - gap to high bios goes hub outside the high smm region
// - top 2 MB high bios goes hub
// - window fields give address bits 31:20
// - inclusive window hit claims graphics port
// - windows decode only with memory enable
// - compatible smm legacy range goes dram for processor smm cycles only, others go hub
module smd_decoder (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_req_valid,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [1:0]  i_req_init,
  input  wire logic        i_req_smm,
  input  wire logic        i_req_writeback,
  input  wire logic [31:0] i_top_of_system_memory,
  input  wire logic        i_high_smm_enable,
  input  wire logic        i_top_smm_enable,
  input  wire logic        i_compat_smm_enable,
  input  wire logic [1:0]  i_upper_smm_size_field,
  input  wire logic [31:0] i_drive_compensation_base,
  input  wire logic [11:0] i_gfx_window_base,
  input  wire logic [11:0] i_gfx_window_limit,
  input  wire logic [11:0] i_gfx_prefetch_window_base,
  input  wire logic [11:0] i_gfx_prefetch_window_limit,
  input  wire logic        i_bridge_command_mem_enable,
  output logic             o_rsp_valid,
  output logic [2:0]       o_rsp_target,
  output logic [31:0]      o_rsp_addr,
  output logic             o_rsp_abort,
  output logic [31:0]      o_top_of_usable_dram,
  output logic [31:0]      o_top_smm_base
);

  smd_win_if win_mem ();
  smd_win_if win_pf ();

  smd_win_cmp u_win_mem (
    .win (win_mem)
  );
  smd_win_cmp u_win_pf (
    .win (win_pf)
  );

  // both windows see the same address; fields supply bits 31:20
  assign win_mem.addr  = i_req_addr;
  assign win_mem.base  = i_gfx_window_base;
  assign win_mem.limit = i_gfx_window_limit;
  assign win_pf.addr   = i_req_addr;
  assign win_pf.base   = i_gfx_prefetch_window_base;
  assign win_pf.limit  = i_gfx_prefetch_window_limit;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [31:0] top_smm_region_bytes(input logic [1:0] f);
    case (f)
      2'h0:    top_smm_region_bytes = smd_pkg::TOP_SMM_REGION_SZ0;
      2'h1:    top_smm_region_bytes = smd_pkg::TOP_SMM_REGION_SZ1;
      2'h2:    top_smm_region_bytes = smd_pkg::TOP_SMM_REGION_SZ2;
      default: top_smm_region_bytes = smd_pkg::TOP_SMM_REGION_SZ3;
    endcase
  endfunction

  logic [31:0] top_smm_region_size;
  logic [31:0] top_smm_region_base;
  logic [31:0] usable_top;

  always_comb begin
    top_smm_region_size = i_top_smm_enable ? top_smm_region_bytes(i_upper_smm_size_field) : '0;
    // size field cannot exceed one megabyte, enforced here too
    if (top_smm_region_size > smd_pkg::TOP_SMM_REGION_MAX) begin
      top_smm_region_size = smd_pkg::TOP_SMM_REGION_MAX;
    end
    usable_top = i_top_of_system_memory - top_smm_region_size;
    top_smm_region_base  = usable_top;
  end

  logic        is_cpu;
  logic        hit_high_smm_region;
  logic        hit_top_smm_region;
  logic        hit_compat;
  logic        hit_win;
  logic        hit_drive_compensation;
  logic [2:0]  tgt_next;
  logic [31:0] addr_next;
  logic        abort_next;

  always_comb begin
    is_cpu     = (i_req_init == smd_pkg::SMD_INIT_CPU);
    hit_high_smm_region   = i_high_smm_enable &&
                 in_range(i_req_addr, smd_pkg::HIGH_SMM_REGION_BASE, smd_pkg::HIGH_SMM_REGION_LAST);
    hit_top_smm_region   = i_top_smm_enable && (top_smm_region_size != '0) &&
                 in_range(i_req_addr, top_smm_region_base, i_top_of_system_memory - 32'h1);
    hit_compat = i_compat_smm_enable &&
                 in_range(i_req_addr, smd_pkg::LEGACY_GFX_BASE, smd_pkg::LEGACY_GFX_LAST);
    hit_win    = i_bridge_command_mem_enable && (win_mem.hit || win_pf.hit);
    hit_drive_compensation  = in_range(i_req_addr, i_drive_compensation_base,
                          i_drive_compensation_base + smd_pkg::DRIVE_COMPENSATION_SIZE - 32'h1);
    tgt_next   = smd_pkg::SMD_TGT_HUB;
    addr_next  = i_req_addr;
    abort_next = 1'b0;
    if (hit_high_smm_region) begin
      if (!is_cpu) begin
        tgt_next = smd_pkg::SMD_TGT_HUB;
      end else if (i_req_smm || i_req_writeback) begin
        // remapped; the dram behind the high region is never addressed
        tgt_next  = smd_pkg::SMD_TGT_DRAM;
        addr_next = i_req_addr - smd_pkg::HIGH_SMM_REGION_OFFSET;
      end else begin
        tgt_next   = smd_pkg::SMD_TGT_ABORT;
        abort_next = 1'b1;
      end
    end else if (hit_top_smm_region) begin
      if (!is_cpu) begin
        tgt_next = smd_pkg::SMD_TGT_HUB;
      end else if (i_req_smm || i_req_writeback) begin
        tgt_next = smd_pkg::SMD_TGT_DRAM;
      end else begin
        tgt_next   = smd_pkg::SMD_TGT_ABORT;
        abort_next = 1'b1;
      end
    end else if (hit_compat) begin
      // non-smm or non-processor cycles fall to the video buffer path
      if (is_cpu && i_req_smm) begin
        tgt_next = smd_pkg::SMD_TGT_DRAM;
      end else begin
        tgt_next = smd_pkg::SMD_TGT_HUB;
      end
    end else if (hit_win) begin
      tgt_next = smd_pkg::SMD_TGT_GFX;
    end else if (i_req_addr < usable_top) begin
      tgt_next = smd_pkg::SMD_TGT_DRAM;
    end else if (hit_drive_compensation) begin
      tgt_next = smd_pkg::SMD_TGT_CFG;
    end else if (in_range(i_req_addr, smd_pkg::IOAPIC_BASE, smd_pkg::IOAPIC_LAST)) begin
      tgt_next = smd_pkg::SMD_TGT_HUB;
    end else if (in_range(i_req_addr, smd_pkg::GAP_BASE, smd_pkg::GAP_LAST)) begin
      tgt_next = smd_pkg::SMD_TGT_HUB;
    end else if (i_req_addr >= smd_pkg::HIBIOS_BASE) begin
      tgt_next = smd_pkg::SMD_TGT_HUB;
    end else begin
      tgt_next = smd_pkg::SMD_TGT_HUB;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
    end else begin
      o_rsp_valid <= i_req_valid;
    end
  end

  // answer fields only change on a valid request so they hold between
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_target <= smd_pkg::SMD_TGT_HUB;
      o_rsp_addr   <= '0;
      o_rsp_abort  <= 1'b0;
    end else if (i_req_valid) begin
      o_rsp_target <= tgt_next;
      o_rsp_addr   <= addr_next;
      o_rsp_abort  <= abort_next;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_top_of_usable_dram <= '0;
      o_top_smm_base       <= '0;
    end else begin
      o_top_of_usable_dram <= usable_top;
      o_top_smm_base       <= top_smm_region_base;
    end
  end

endmodule

// File: smd_pkg.sv
// shared constants and types for the smm and window address decoder
package smd_pkg;

  localparam int          ADDR_W          = 32;
  localparam int          WIN_W           = 12;
  localparam int          MB_SHIFT        = 20;
  localparam int          UPPER_SMM_SIZE_FIELD_W          = 2;

  localparam logic [31:0] LEGACY_GFX_BASE = 32'h000A_0000;
  localparam logic [31:0] LEGACY_GFX_LAST = 32'h000B_FFFF;
  localparam logic [31:0] HIGH_SMM_REGION_BASE       = 32'hFEDA_0000;
  localparam logic [31:0] HIGH_SMM_REGION_LAST       = 32'hFEDB_FFFF;
  localparam logic [31:0] HIGH_SMM_REGION_OFFSET     = HIGH_SMM_REGION_BASE - LEGACY_GFX_BASE;
  localparam logic [31:0] IOAPIC_BASE     = 32'hFEC0_0000;
  localparam logic [31:0] IOAPIC_LAST     = 32'hFECF_FFFF;
  localparam logic [31:0] GAP_BASE        = 32'hFED0_0000;
  localparam logic [31:0] GAP_LAST        = 32'hFFDF_FFFF;
  localparam logic [31:0] HIBIOS_BASE     = 32'hFFE0_0000;
  localparam logic [31:0] DRIVE_COMPENSATION_SIZE      = 32'h0000_1000;
  localparam logic [19:0] WIN_LOW_BASE    = 20'h0_0000;
  localparam logic [19:0] WIN_LOW_LIMIT   = 20'hF_FFFF;
  localparam logic [31:0] TOP_SMM_REGION_MAX        = 32'h0010_0000;

  // upper smm size field encoding to bytes
  localparam logic [31:0] TOP_SMM_REGION_SZ0        = 32'h0000_0000;
  localparam logic [31:0] TOP_SMM_REGION_SZ1        = 32'h0002_0000;
  localparam logic [31:0] TOP_SMM_REGION_SZ2        = 32'h0008_0000;
  localparam logic [31:0] TOP_SMM_REGION_SZ3        = 32'h0010_0000;

  typedef enum logic [1:0] {
    SMD_INIT_CPU = 2'h0,
    SMD_INIT_GFX = 2'h1,
    SMD_INIT_HUB = 2'h2
  } smd_init_e;

  typedef enum logic [2:0] {
    SMD_TGT_DRAM  = 3'h0,
    SMD_TGT_HUB   = 3'h1,
    SMD_TGT_GFX   = 3'h2,
    SMD_TGT_ABORT = 3'h3,
    SMD_TGT_CFG   = 3'h4
  } smd_target_e;

  typedef enum logic [1:0] {
    SMD_ST_IDLE = 2'b00,
    SMD_ST_BUSY = 2'b01
  } smd_state_e;

endpackage

// File: smd_win_if.sv
// carrier for graphics window compare requests and answers
`timescale 1ns/1ps
interface smd_win_if;
  logic [31:0] addr;
  logic [11:0] base;
  logic [11:0] limit;
  logic        hit;
  modport owner (output addr, output base, output limit, input hit);
  modport cmp   (input addr, input base, input limit, output hit);
endinterface

// File: smd_win_cmp.sv
// one graphics window range compare
`timescale 1ns/1ps
module smd_win_cmp (
  smd_win_if.cmp win
);
  logic [31:0] lo;
  logic [31:0] hi;
  always_comb begin
    lo      = {win.base, smd_pkg::WIN_LOW_BASE};
    hi      = {win.limit, smd_pkg::WIN_LOW_LIMIT};
    win.hit = (win.addr >= lo) && (win.addr <= hi);
  end
endmodule

// File: smd_decoder_chk.sv
// port assertions for the smm and window address decoder
`timescale 1ns/1ps
module smd_decoder_chk (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic [1:0]  i_req_init,
  input wire logic        i_req_smm,
  input wire logic        i_req_writeback,
  input wire logic        i_high_smm_enable,
  input wire logic        i_bridge_command_mem_enable,
  input wire logic        o_rsp_valid,
  input wire logic [2:0]  o_rsp_target,
  input wire logic [31:0] o_rsp_addr,
  input wire logic        o_rsp_abort
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire logic hs = i_high_smm_enable && i_req_addr >= smd_pkg::HIGH_SMM_REGION_BASE
    && i_req_addr <= smd_pkg::HIGH_SMM_REGION_LAST;
  wire logic cpu = i_req_init == smd_pkg::SMD_INIT_CPU;
  sequence s_hs_cpu; i_req_valid && hs && cpu; endsequence
  property p_hs_smm; s_hs_cpu ##0 i_req_smm |=> o_rsp_target == smd_pkg::SMD_TGT_DRAM
    && o_rsp_addr == $past(i_req_addr) - smd_pkg::HIGH_SMM_REGION_OFFSET; endproperty
  a_hs_smm: assert property (p_hs_smm) else $error("high region remap wrong");
  property p_hs_bad; s_hs_cpu ##0 !i_req_smm && !i_req_writeback
    |=> o_rsp_abort && o_rsp_target == smd_pkg::SMD_TGT_ABORT; endproperty
  a_hs_bad: assert property (p_hs_bad) else $error("high region not aborted");
  property p_hs_wb; s_hs_cpu ##0 i_req_writeback
    |=> !o_rsp_abort && o_rsp_target == smd_pkg::SMD_TGT_DRAM; endproperty
  a_hs_wb: assert property (p_hs_wb) else $error("writeback not remapped");
  property p_hs_ext; i_req_valid && hs && !cpu |=> o_rsp_target == smd_pkg::SMD_TGT_HUB;
  endproperty
  a_hs_ext: assert property (p_hs_ext) else $error("outside cycle reached smm");
  property p_apic; i_req_valid && i_req_addr >= smd_pkg::IOAPIC_BASE
    && i_req_addr <= smd_pkg::IOAPIC_LAST |=> o_rsp_target == smd_pkg::SMD_TGT_HUB; endproperty
  a_apic: assert property (p_apic) else $error("apic space not to hub");
  property p_bios; i_req_valid && i_req_addr >= smd_pkg::HIBIOS_BASE
    |=> o_rsp_target == smd_pkg::SMD_TGT_HUB; endproperty
  a_bios: assert property (p_bios) else $error("high bios not to hub");
  property p_win_off; i_req_valid && !i_bridge_command_mem_enable
    |=> o_rsp_target != smd_pkg::SMD_TGT_GFX; endproperty
  a_win_off: assert property (p_win_off) else $error("window decoded while off");
  property p_ans; i_req_valid |=> o_rsp_valid ##1 (o_rsp_valid == $past(i_req_valid));
  endproperty
  a_ans: assert property (p_ans) else $error("answer pulse wrong");
endmodule
bind smd_decoder smd_decoder_chk u_chk (.*);

// File: smd_req_model.sv
// requester model for the processor bus and downstream hubs
`timescale 1ns/1ps
module smd_req_model (
  input  wire logic        i_clock,
  output logic             o_valid,
  output logic [31:0]      o_addr,
  output logic [1:0]       o_init,
  output logic             o_smm,
  output logic             o_wb
);
  initial {o_valid, o_addr, o_init, o_smm, o_wb} = '0;
  // released address shows the inverse so a stale value never decodes as valid
  task issue(input logic [31:0] a, input logic [1:0] n, input logic s, w);
    @(posedge i_clock);
    {o_valid, o_addr, o_init, o_smm, o_wb} <= {1'h1, a, n, s, w};
    @(posedge i_clock);
    o_valid <= 1'h0;
    o_addr  <= ~a;
  endtask
endmodule

// File: test_smd_decoder.sv
// self-checking bench for the smm and window address decoder
`timescale 1ns/1ps
module test_smd_decoder;
  typedef struct packed {logic [31:0] a; logic [1:0] n; logic s, w; logic [2:0] t;} smd_row_s;
  localparam logic [2:0] TD = smd_pkg::SMD_TGT_DRAM, TH = smd_pkg::SMD_TGT_HUB;
  localparam logic [2:0] TG = smd_pkg::SMD_TGT_GFX, TA = smd_pkg::SMD_TGT_ABORT;
  localparam logic [2:0] TC = smd_pkg::SMD_TGT_CFG;
  localparam logic [1:0] C = smd_pkg::SMD_INIT_CPU, G = smd_pkg::SMD_INIT_GFX;
  localparam logic [1:0] H = smd_pkg::SMD_INIT_HUB;
  logic i_clock = 1'h0, i_rst_n = 1'h0, i_bridge_command_mem_enable = 1'h1;
  logic i_high_smm_enable = 1'h1, i_top_smm_enable = 1'h1, i_compat_smm_enable = 1'h1;
  logic [1:0]  i_upper_smm_size_field = 2'h3;
  logic [31:0] i_top_of_system_memory = 32'h0400_0000, i_drive_compensation_base = 32'h0800_0000;
  logic [11:0] i_gfx_window_base = 12'h0E0, i_gfx_window_limit = 12'h0E0;
  logic [11:0] i_gfx_prefetch_window_base = 12'h0D0, i_gfx_prefetch_window_limit = 12'h0D1;
  wire logic        i_req_valid, i_req_smm, i_req_writeback, o_rsp_valid, o_rsp_abort;
  wire logic [1:0]  i_req_init;
  wire logic [2:0]  o_rsp_target;
  wire logic [31:0] i_req_addr, o_rsp_addr, o_top_of_usable_dram, o_top_smm_base;
  logic [31:0] sz [4] = '{smd_pkg::TOP_SMM_REGION_SZ0, smd_pkg::TOP_SMM_REGION_SZ1, smd_pkg::TOP_SMM_REGION_SZ2,
    smd_pkg::TOP_SMM_REGION_SZ3};
  int n_errors = 0, n_checks = 0;
  smd_row_s rows [18] = '{
    '{32'hFEDA_0010, C, 1'h1, 1'h0, TD}, '{32'hFEDB_0000, C, 1'h0, 1'h0, TA},
    '{32'hFEDA_0000, C, 1'h0, 1'h1, TD}, '{32'hFEDA_0000, G, 1'h1, 1'h0, TH},
    '{32'h03F0_0040, C, 1'h1, 1'h0, TD}, '{32'h03FF_FFFF, C, 1'h0, 1'h0, TA},
    '{32'h03F8_0000, C, 1'h0, 1'h1, TD}, '{32'h03F0_0000, H, 1'h1, 1'h0, TH},
    '{32'h03EF_FFFF, C, 1'h0, 1'h0, TD}, '{32'h0800_0FFF, C, 1'h0, 1'h0, TC},
    '{32'h0900_0000, C, 1'h0, 1'h0, TH}, '{32'hFEC0_F000, C, 1'h0, 1'h0, TH},
    '{32'hFED0_0000, C, 1'h0, 1'h0, TH}, '{32'hFFE0_0000, C, 1'h0, 1'h0, TH},
    '{32'h0E0F_FFFF, C, 1'h0, 1'h0, TG}, '{32'h0D00_0000, C, 1'h0, 1'h0, TG},
    '{32'h0E10_0000, C, 1'h0, 1'h0, TH}, '{32'h000A_0000, C, 1'h1, 1'h0, TD}};
  smd_decoder dut (.*);
  smd_req_model m (.i_clock(i_clock), .o_valid(i_req_valid), .o_addr(i_req_addr),
    .o_init(i_req_init), .o_smm(i_req_smm), .o_wb(i_req_writeback));
  task chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task run(input smd_row_s r);
    m.issue(r.a, r.n, r.s, r.w);
    #1;
    chk(o_rsp_valid, 1'h1);
    chk(o_rsp_target, r.t);
    chk(o_rsp_abort, r.t == TA);
    // high region smm and writeback hits come back shifted down onto the legacy range
    if (r.t != TA) chk(o_rsp_addr, (r.t == TD && r.a >= smd_pkg::HIGH_SMM_REGION_BASE) ?
      r.a - smd_pkg::HIGH_SMM_REGION_OFFSET : r.a);
    // the answer strobe lasts one cycle while the target keeps its value
    @(posedge i_clock);
    #1;
    chk(o_rsp_valid, 1'h0);
    chk(o_rsp_target, r.t);
  endtask
  initial forever #10 i_clock = ~i_clock;
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge i_clock);
    chk(o_rsp_valid, 1'h0);
    chk(o_rsp_target, TH);
    i_rst_n <= 1'h1;
    repeat (2) @(posedge i_clock);
    #1;
    chk(o_top_of_usable_dram, i_top_of_system_memory - sz[3]);
    chk(o_top_smm_base, i_top_of_system_memory - sz[3]);
    $display("reset and status done");
    foreach (rows[i]) run(rows[i]);
    $display("row table done");
    @(posedge i_clock);
    i_bridge_command_mem_enable <= 1'h0;
    run('{32'h0E00_0000, C, 1'h0, 1'h0, TH});
    @(posedge i_clock);
    i_bridge_command_mem_enable <= 1'h1;
    $display("window enable done");
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      i_upper_smm_size_field <= k[1:0];
      repeat (2) @(posedge i_clock);
      #1;
      chk(o_top_of_usable_dram, i_top_of_system_memory - sz[k]);
    end
    $display("size field done");
    complete_run;
  end
endmodule
